// ---- logic/timer_pair_defs.svh ----
// Constants of the timer pair control block: register offsets, bit positions, reset values.
// Assumes inclusion by its bare name from the package and the design modules.
// Function
// RL1: Width bit joins channels into 16-bit timer; the block only passes the bit out on o_pair_width_select.
// RL2: Rejector bit filters external clock input 1.
// RL3: Inverted channel 2 clock out when enabled.
// RL4: Channel 2 clock out when enabled.
// RL5: Run bit lets channel 2 count; resets stopped.
// RL6: Preset bit write-only, reads zero, 1 presets.
// RL7: Clock-select bit picks external or internal clock.
// RL8: Preset loads reload data; reload resets ones.
// RL9: Bit 5 reads zero, writes ignored.
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH
`define CTRL_OFFSET       16'hff38
`define RELOAD_OFFSET     16'hff3a
`define COUNT_OFFSET      16'hff3c
`define BIT_WIDTH_SEL     7
`define BIT_FILTER_EN     6
`define BIT_UNUSED        5
`define BIT_INV_OUT       4
`define BIT_CLK_OUT       3
`define BIT_RUN           2
`define BIT_PRESET        1
`define BIT_CLK_SRC       0
`define CTRL_RESET        8'h00
`define RELOAD_RESET      8'hff
`define CTRL_RW_MASK      8'hdd
`define FILTER_STAGES     3
`endif

// ---- logic/timer_pair_pkg.sv ----
// Types shared by the timer pair control block.
// Assumes the constants header is on the include path.
package timer_pair_pkg;
  `include "timer_pair_defs.svh"
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

// ---- logic/clk_noise_filter.sv ----
// External clock input conditioner with optional noise rejection.
// Assumes an asynchronous pin input and a single system clock.
`timescale 1ns/10ps
`include "timer_pair_defs.svh"
module clk_noise_filter
  import timer_pair_pkg::*;
#(
  parameter int STAGES = `FILTER_STAGES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_pin,
  input  wire logic i_filter_en,
  output logic      o_level
);
  logic [2:0]        sync;
  logic [2:0]        next_sync;
  logic [STAGES-1:0] hist;
  logic [STAGES-1:0] next_hist;
  logic              level;
  logic              next_level;

  // Three-stage synchroniser; only stages two and three are compared.
  always_comb begin
    next_sync = {sync[1:0], i_pin};
    next_hist = {hist[STAGES-2:0], sync[2]};
    next_level = level;
    if (sync[1] == sync[2]) begin
      if (!i_filter_en) begin
        next_level = sync[2]; // RL2
      end else if (&{hist, sync[2]}) begin
        next_level = 1'b1; // RL2
      end else if (~|{hist, sync[2]}) begin
        next_level = 1'b0; // RL2
      end
    end
  end

  // Filtering costs STAGES cycles of latency, traded for glitch immunity.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync  <= 3'h0;
      hist  <= '0;
      level <= 1'b0;
    end else begin
      sync  <= next_sync;
      hist  <= next_hist;
      level <= next_level;
    end
  end

  assign o_level = level;
endmodule

// ---- logic/timer_pair_ctrl.sv ----
// Control register and channel 2 counter of a programmable timer pair, with an Avalon-MM slave.
// Assumes one 100 MHz clock, an internal count enable pulse and an asynchronous external clock pin.
`timescale 1ns/10ps
`include "timer_pair_defs.svh"
module timer_pair_ctrl
  import timer_pair_pkg::*;
#(
  parameter int FILTER_STAGES = `FILTER_STAGES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_writedata,
  output logic [7:0]       o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_int_clk_en,
  input  wire logic        i_ext_clk1,
  output logic             o_pair_width_select,
  output logic [7:0]       o_ch2_count,
  output logic             o_ch2_clk_out,
  output logic             o_ch2_inv_clk_out
);
  bus_state_t  state;
  bus_state_t  next_state;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [7:0]  reload;
  logic [7:0]  next_reload;
  logic [7:0]  count;
  logic [7:0]  next_count;
  logic [7:0]  rdata;
  logic [7:0]  next_rdata;
  logic        tclk;
  logic        next_tclk;
  logic        ext_q;
  logic        next_ext_q;
  logic        ext_level;
  logic        tick;
  logic        preset_req;
  logic        bus_commit;
  logic        hit_ctrl;
  logic        hit_reload;
  logic        hit_count;
  logic        clk_out;
  logic        next_clk_out;
  logic        inv_clk_out;
  logic        next_inv_clk_out;

  // One compare serves every decoder below, so a change of the address width touches one place.
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // The storable image of the control byte: the preset bit and the unused bit are never kept.
  // Using the same mask on write and on read keeps both bits at zero whatever software writes.
  function automatic logic [7:0] ctrl_image(input logic [7:0] value);
    ctrl_image = value & `CTRL_RW_MASK;
  endfunction

  // Byte selects of the three mapped locations; every other address is a hole.
  assign hit_ctrl   = addr_hit(i_address, `CTRL_OFFSET);
  assign hit_reload = addr_hit(i_address, `RELOAD_OFFSET);
  assign hit_count  = addr_hit(i_address, `COUNT_OFFSET);

  // A write commits only in the answer cycle, the one edge at which the master sees waitrequest low.
  assign bus_commit = (state == BUS_ANSWER) && i_write;

  // External clock input 1, filtered or bypassed by the rejector bit.
  clk_noise_filter #(
    .STAGES (FILTER_STAGES)
  ) u_filter (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_pin       (i_ext_clk1),
    .i_filter_en (ctrl[`BIT_FILTER_EN]),
    .o_level     (ext_level)
  );

  // Edge detector state. It resets low like the filter output, so lifting reset shows no false edge.
  always_comb begin
    next_ext_q = ext_level;
  end

  // Registers the previous level of the conditioned external clock.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= next_ext_q;
    end
  end

  // Count source: rising edge of the conditioned external clock, or the internal enable.
  // The internal enable must be a single-cycle pulse; a held enable counts on every cycle.
  assign tick = ctrl[`BIT_CLK_SRC] ? (ext_level & ~ext_q) : i_int_clk_en; // RL7

  // A committed control write with the preset bit set is a one-cycle preset request.
  // The bit itself is never stored, so there is nothing to clear afterwards.
  assign preset_req = bus_commit && hit_ctrl && i_writedata[`BIT_PRESET]; // RL6

  // Bus slave: every access answers in the cycle after it is seen, so waitrequest drops then.
  // Read data is captured when the request is taken and stands until the next read.
  // The fixed single wait state keeps the decoder off the path from address to read data.
  always_comb begin
    next_state = state;
    next_rdata = rdata;
    unique case (state)
      BUS_IDLE: begin
        if (i_read || i_write) begin
          next_state = BUS_ANSWER;
        end
        if (i_read) begin
          if (hit_ctrl) begin
            next_rdata = ctrl_image(ctrl); // RL6 RL9
          end else if (hit_reload) begin
            next_rdata = reload;
          end else if (hit_count) begin
            next_rdata = count;
          end else begin
            next_rdata = 8'h00;
          end
        end
      end
      BUS_ANSWER: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  // Bus slave state and read data register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= BUS_IDLE;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  // Register file: writes to holes are dropped, and the control byte keeps only its storable bits.
  always_comb begin
    next_ctrl   = ctrl;
    next_reload = reload;
    if (bus_commit) begin
      if (hit_ctrl) begin
        next_ctrl = ctrl_image(i_writedata); // RL9
      end else if (hit_reload) begin
        next_reload = i_writedata;
      end
    end
  end

  // Control resets to all zero, so after reset the counter is stopped and both clock outputs are off.
  // Reload resets to all ones, so a preset before any reload write loads 0xff.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl   <= `CTRL_RESET; // RL1 RL2 RL5 RL7
      reload <= `RELOAD_RESET; // RL8
    end else begin
      ctrl   <= next_ctrl;
      reload <= next_reload;
    end
  end

  // Down counter; a preset wins over counting in the same cycle. At zero the next tick reloads
  // and toggles the channel clock, so one channel clock period spans two reload intervals.
  // A preset does not touch the channel clock, so its phase survives a restart.
  always_comb begin
    next_count = count;
    next_tclk  = tclk;
    if (preset_req) begin
      next_count = reload; // RL8
    end else if (ctrl[`BIT_RUN] && tick) begin // RL5
      if (count == 8'h00) begin
        next_count = reload;
        next_tclk  = ~tclk;
      end else begin
        next_count = count - 8'h01;
      end
    end
  end

  // Counter and channel clock registers.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= 8'h00;
      tclk  <= 1'b0;
    end else begin
      count <= next_count;
      tclk  <= next_tclk;
    end
  end

  // Clock outputs come from flops so a control write and an underflow on one edge cannot glitch the pins.
  // They are built from next values, so they change on the same edge as the bits that gate them.
  always_comb begin
    next_clk_out     = next_ctrl[`BIT_CLK_OUT] & next_tclk; // RL4
    next_inv_clk_out = next_ctrl[`BIT_INV_OUT] & ~next_tclk; // RL3
  end

  // Clock output registers; both pins are low during reset.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_out     <= 1'b0;
      inv_clk_out <= 1'b0;
    end else begin
      clk_out     <= next_clk_out;
      inv_clk_out <= next_inv_clk_out;
    end
  end

  // Waitrequest is high except in the answer cycle; it is decoded from the state flop alone.
  // The block does not chain the two channels itself; the width bit is only passed out.
  assign o_waitrequest       = (state != BUS_ANSWER);
  assign o_readdata          = rdata;
  assign o_ch2_count         = count;
  assign o_pair_width_select = ctrl[`BIT_WIDTH_SEL]; // RL1
  assign o_ch2_clk_out       = clk_out;
  assign o_ch2_inv_clk_out   = inv_clk_out;
endmodule

// ---- sim/timer_pair_monitor.sv ----
// Port checker for the timer pair control block.
// Assumes it is bound to timer_pair_ctrl and shares its clock and reset.
`timescale 1ns/10ps
module timer_pair_monitor (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [7:0]  i_writedata,
  input  wire logic [7:0]  o_readdata,
  input  wire logic        o_waitrequest,
  input  wire logic        o_pair_width_select,
  input  wire logic [7:0]  o_ch2_count,
  input  wire logic        o_ch2_clk_out,
  input  wire logic        o_ch2_inv_clk_out
);
  logic [7:0] sh;
  logic [7:0] rl;
  wire        wc = i_write && !o_waitrequest && i_address == 16'hff38;
  wire        wr = i_write && !o_waitrequest && i_address == 16'hff3a;
  // Shadow copies, since the control and reload bytes have no port of their own.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh <= 8'h00;
      rl <= 8'hff;
    end else begin
      if (wc) sh <= i_writedata & 8'hdd;
      if (wr) rl <= i_writedata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("answer missing one cycle after request");
  chk_ctrl_read: assert property (i_read && !o_waitrequest && i_address == 16'hff38 |-> o_readdata == sh)
    else $error("control readback wrong");
  chk_width_bit: assert property (o_pair_width_select == sh[7])
    else $error("width output differs from control bit");
  chk_preset_load: assert property (wc && i_writedata[1] |=> o_ch2_count == $past(rl))
    else $error("preset did not load reload value");
  chk_stop_hold: assert property (!sh[2] && !wc |=> $stable(o_ch2_count))
    else $error("count moved while stopped");
  chk_inv_off: assert property (!sh[4] |-> !o_ch2_inv_clk_out)
    else $error("inverted clock out while disabled");
  chk_clk_off: assert property (!sh[3] |-> !o_ch2_clk_out)
    else $error("clock out while disabled");
  chk_out_excl: assert property (!(o_ch2_clk_out && o_ch2_inv_clk_out))
    else $error("both clock outputs high");
endmodule

// ---- sim/test_timer_pair_ctrl.sv ----
// Self-checking bench for the timer pair control block.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/10ps
module test_timer_pair_ctrl;
  logic        i_clk = 0, i_rst_b = 0, i_read = 0, i_write = 0, i_int_clk_en = 0, i_ext_clk1 = 0;
  logic [15:0] i_address = 16'h0000;
  logic [7:0]  i_writedata = 8'h00, o_readdata, o_ch2_count, q;
  logic        o_waitrequest, o_pair_width_select, o_ch2_clk_out, o_ch2_inv_clk_out;
  int          n_mismatch = 0, num_checks = 0;
  timer_pair_ctrl uut (
    .i_clk               (i_clk),
    .i_rst_b             (i_rst_b),
    .i_address           (i_address),
    .i_read              (i_read),
    .i_write             (i_write),
    .i_writedata         (i_writedata),
    .o_readdata          (o_readdata),
    .o_waitrequest       (o_waitrequest),
    .i_int_clk_en        (i_int_clk_en),
    .i_ext_clk1          (i_ext_clk1),
    .o_pair_width_select (o_pair_width_select),
    .o_ch2_count         (o_ch2_count),
    .o_ch2_clk_out       (o_ch2_clk_out),
    .o_ch2_inv_clk_out   (o_ch2_inv_clk_out)
  );
  // Free-running 100 MHz clock.
  always #5 i_clk = ~i_clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // The request holds until the edge at which waitrequest is seen low; read data is taken there.
  // The task returns mid-cycle so that outputs launched by the committing edge have settled.
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    repeat (20) begin
      @(posedge i_clk);
      if (o_waitrequest === 1'b0) break;
    end
    q = o_readdata;
    if (o_waitrequest !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
    i_read <= 0;
    i_write <= 0;
    @(negedge i_clk);
  endtask
  // Two-cycle pin pulse: long enough for the bypass path, too short for the rejector.
  task automatic glitch;
    @(posedge i_clk);
    i_ext_clk1 <= 1;
    repeat (2) @(posedge i_clk);
    i_ext_clk1 <= 0;
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task automatic pulse(input int k, input logic ext);
    repeat (k) begin
      @(posedge i_clk);
      if (ext) i_ext_clk1 <= 1; else i_int_clk_en <= 1;
      @(posedge i_clk);
      i_int_clk_en <= 0;
      repeat (8) @(posedge i_clk);
      i_ext_clk1 <= 0;
      repeat (8) @(posedge i_clk);
    end
    @(negedge i_clk);
  endtask
  task automatic t_regs;
    bus(16'hff38, 0, 8'h00);
    chk(q, 8'h00);
    bus(16'hff3a, 0, 8'h00);
    chk(q, 8'hff);
    bus(16'hff38, 1, 8'hff);
    bus(16'hff38, 0, 8'h00);
    chk(q, 8'hdd);
    chk({7'h00, o_pair_width_select}, 8'h01);
    chk(o_ch2_count, 8'hff);
    chk({7'h00, o_ch2_clk_out ^ o_ch2_inv_clk_out}, 8'h01);
    bus(16'h0000, 1, 8'h5a);
    bus(16'h0000, 0, 8'h00);
    chk(q, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_count;
    bus(16'hff3a, 1, 8'h05);
    bus(16'hff38, 1, 8'h06);
    chk(o_ch2_count, 8'h05);
    pulse(2, 0);
    chk(o_ch2_count, 8'h03);
    bus(16'hff38, 1, 8'h05);
    pulse(1, 0);
    chk(o_ch2_count, 8'h03);
    pulse(1, 1);
    chk(o_ch2_count, 8'h02);
    bus(16'hff38, 1, 8'h45);
    pulse(1, 1);
    chk(o_ch2_count, 8'h01);
    glitch();
    chk(o_ch2_count, 8'h01);
    bus(16'hff38, 1, 8'h05);
    glitch();
    chk(o_ch2_count, 8'h00);
    bus(16'hff38, 1, 8'h01);
    pulse(1, 1);
    chk(o_ch2_count, 8'h00);
    $display("test count done");
  endtask
  task automatic t_out;
    bus(16'hff3a, 1, 8'h01);
    bus(16'hff38, 1, 8'h1e);
    chk(o_ch2_count, 8'h01);
    chk({6'h00, o_ch2_clk_out, o_ch2_inv_clk_out}, 8'h01);
    pulse(2, 0);
    chk(o_ch2_count, 8'h01);
    chk({6'h00, o_ch2_clk_out, o_ch2_inv_clk_out}, 8'h02);
    bus(16'hff3c, 0, 8'h00);
    chk(q, 8'h01);
    bus(16'hff38, 1, 8'h04);
    chk({6'h00, o_ch2_clk_out, o_ch2_inv_clk_out}, 8'h00);
    $display("test out done");
  endtask
  // Reset is held for twelve cycles before any traffic.
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1;
    t_regs();
    t_count();
    t_out();
    end_of_test();
  end
endmodule
bind timer_pair_ctrl timer_pair_monitor mon (
  .i_clk               (i_clk),
  .i_rst_b             (i_rst_b),
  .i_address           (i_address),
  .i_read              (i_read),
  .i_write             (i_write),
  .i_writedata         (i_writedata),
  .o_readdata          (o_readdata),
  .o_waitrequest       (o_waitrequest),
  .o_pair_width_select (o_pair_width_select),
  .o_ch2_count         (o_ch2_count),
  .o_ch2_clk_out       (o_ch2_clk_out),
  .o_ch2_inv_clk_out   (o_ch2_inv_clk_out)
);
